// file: hw/cellbus_regs.svh
// Timing and layout constants for the input cell bus port
`ifndef CELLBUS_REGS_SVH
`define CELLBUS_REGS_SVH
`define CELL_WORDS 5'h1b
`define INBAND_WORDS 5'h1c
`define IDLE_ADDR 5'h1f
`define N_CHAN 32
`define LINK_PERIOD_NS 40
`define SYS_PERIOD_NS 5
`define LINK_DIV (`LINK_PERIOD_NS / `SYS_PERIOD_NS)
`define LINK_RISE_AT 3'h3
`define LINK_FALL_AT 3'h7
`define WORD_ZERO 16'h0000
`endif

// file: hw/cellbus_pkg.sv
// Shared types for both ends of the input cell bus port
package cellbus_pkg;
	typedef logic [4:0] phy_addr_t;
	typedef logic [15:0] cell_word_t;
	typedef enum logic [3:0] {
		M_POLL = 4'b0001,
		M_GAP = 4'b0010,
		M_SEL = 4'b0100,
		M_XFER = 4'b1000
	} master_state_t;
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_POLL = 4'b0010,
		H_WAIT = 4'b0100,
		H_XFER = 4'b1000
	} host_state_t;
	typedef struct packed {
		logic sop;
		logic eop;
		phy_addr_t chan;
		cell_word_t word;
	} beat_t;
endpackage

// file: hw/cell_link_if.sv
// Cell bus link between the port and its bus partner
`timescale 1ns/1ps
interface cell_link_if;
	logic in_if_clock;
	logic enb_dev_o, enb_dev_oe, enb_host_o, enb_host_oe;
	logic [4:0] addr_dev_o, addr_host_o;
	logic addr_dev_oe, addr_host_oe;
	logic valid_dev_o, valid_dev_oe, valid_host_o, valid_host_oe;
	logic avail_dev_o, avail_dev_oe, avail_host_o, avail_host_oe;
	logic [15:0] in_cell_word;
	logic in_start_xfer;
	logic in_start_of_cell;
	logic in_xfer_enable_n;
	logic [4:0] in_phy_addr;
	logic in_addr_valid;
	logic in_cell_avail;
	// Pull-up on the enable, idle address otherwise
	assign in_xfer_enable_n = enb_dev_oe ? enb_dev_o : (enb_host_oe ? enb_host_o : 1'b1);
	assign in_phy_addr = addr_dev_oe ? addr_dev_o : (addr_host_oe ? addr_host_o : 5'h1f);
	assign in_addr_valid = valid_dev_oe ? valid_dev_o : (valid_host_oe ? valid_host_o : 1'b0);
	assign in_cell_avail = avail_dev_oe ? avail_dev_o : (avail_host_oe ? avail_host_o : 1'b0);
	modport dev (
		input in_if_clock, in_xfer_enable_n, in_phy_addr, in_addr_valid, in_cell_avail,
		input in_cell_word, in_start_xfer, in_start_of_cell,
		output enb_dev_o, enb_dev_oe, addr_dev_o, addr_dev_oe,
		output valid_dev_o, valid_dev_oe, avail_dev_o, avail_dev_oe
	);
	modport host (
		output in_if_clock, in_cell_word, in_start_xfer, in_start_of_cell,
		output enb_host_o, enb_host_oe, addr_host_o, addr_host_oe,
		output valid_host_o, valid_host_oe, avail_host_o, avail_host_oe,
		input in_xfer_enable_n, in_phy_addr, in_addr_valid, in_cell_avail
	);
endinterface // cell_link_if

// file: hw/cellbus_dev.sv
// Device end of the input cell bus port: master poller and slave receiver
`timescale 1ns/1ps
`include "cellbus_regs.svh"
module cellbus_dev (
	// System side
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Mode straps, asynchronous to the link
	input wire logic parallel_bus_select_in,
	input wire logic in_master_select_in,
	input wire logic in_inband_proto_select_in,
	// Per-channel free space, quasi-static
	input wire logic [`N_CHAN-1:0] chan_space_in,
	// Received words
	output logic [15:0] rx_word_out,
	output logic [4:0] rx_chan_out,
	output logic rx_sop_out,
	output logic rx_eop_out,
	output logic rx_valid_out,
	// Link
	cell_link_if.dev link
);
	logic lrst_meta_reg, lrst_reg;
	logic [2:0] mode_meta_reg, mode_reg;
	logic [`N_CHAN-1:0] space_meta_reg, space_reg;
	logic act, mst, slv, ib;
	cellbus_pkg::master_state_t m_state_reg;
	cellbus_pkg::phy_addr_t ptr_reg, sel_reg;
	logic [4:0] mcnt_reg, rcnt_reg;
	logic mpipe_reg, polled_reg;
	logic enb_o_reg, addr_oe_reg, valid_o_reg, avail_o_reg, avail_oe_reg;
	logic [4:0] addr_o_reg;
	logic ib_poll_reg;
	cellbus_pkg::phy_addr_t ib_addr_reg, slv_chan_reg, cur_chan_reg;
	logic busy_reg, ib_sel_reg;
	logic beat_reg;
	cellbus_pkg::beat_t beat_next, hold_reg;
	logic take, poll_act;
	logic [4:0] last_cnt;
	logic tog_reg, tog_meta_reg, tog_sync_reg, tog_prev_reg;

	function automatic logic chan_ok(input logic [`N_CHAN-1:0] space, input logic [4:0] a,
		input logic busy, input logic [4:0] cur);
		chan_ok = space[a] && !(busy && cur == a);
	endfunction

	// Reset and straps cross into the link clock
	always_ff @(posedge link.in_if_clock)
	begin
		lrst_meta_reg <= rst_in;
		lrst_reg <= lrst_meta_reg;
		mode_meta_reg <= {in_inband_proto_select_in, in_master_select_in, parallel_bus_select_in};
		mode_reg <= mode_meta_reg;
		space_meta_reg <= chan_space_in;
		space_reg <= space_meta_reg;
	end

	assign act = mode_reg[0];
	assign ib = mode_reg[2];
	assign mst = act && mode_reg[1] && !ib;
	assign slv = act && !mode_reg[1];
	assign poll_act = ib ? !link.in_addr_valid : link.in_addr_valid;
	assign last_cnt = ib ? `INBAND_WORDS - 5'h01 : `CELL_WORDS - 5'h01;

	// Master poll, select and pull
	always_ff @(posedge link.in_if_clock)
	begin
		if (lrst_reg || !mst)
		begin
			m_state_reg <= cellbus_pkg::M_POLL;
			ptr_reg <= 5'h00;
			sel_reg <= 5'h00;
			mcnt_reg <= 5'h00;
			mpipe_reg <= 1'b0;
			polled_reg <= 1'b0;
			enb_o_reg <= 1'b1;
			addr_o_reg <= `IDLE_ADDR;
			valid_o_reg <= 1'b0;
			addr_oe_reg <= 1'b0;
		end
		else
		begin
			addr_oe_reg <= 1'b1;
			mpipe_reg <= (m_state_reg == cellbus_pkg::M_XFER);
			case (m_state_reg)
				cellbus_pkg::M_POLL:
				begin
					// Answer to the last poll stood on the bus during the gap cycle
					if (polled_reg && link.in_cell_avail)
					begin
						addr_o_reg <= sel_reg;
						valid_o_reg <= 1'b0;
						m_state_reg <= cellbus_pkg::M_SEL;
					end
					else
					begin
						addr_o_reg <= ptr_reg;
						valid_o_reg <= 1'b1;
						sel_reg <= ptr_reg;
						m_state_reg <= cellbus_pkg::M_GAP;
					end
					polled_reg <= 1'b0;
				end
				cellbus_pkg::M_GAP:
				begin
					addr_o_reg <= `IDLE_ADDR;
					valid_o_reg <= 1'b0;
					ptr_reg <= ptr_reg + 5'h01;
					polled_reg <= 1'b1;
					m_state_reg <= cellbus_pkg::M_POLL;
				end
				cellbus_pkg::M_SEL:
				begin
					enb_o_reg <= 1'b0;
					addr_o_reg <= `IDLE_ADDR;
					mcnt_reg <= 5'h00;
					m_state_reg <= cellbus_pkg::M_XFER;
				end
				cellbus_pkg::M_XFER:
				begin
					mcnt_reg <= mcnt_reg + 5'h01;
					if (mcnt_reg == `CELL_WORDS - 5'h01)
					begin
						enb_o_reg <= 1'b1;
						m_state_reg <= cellbus_pkg::M_POLL;
					end
				end
				default:
				begin
					m_state_reg <= cellbus_pkg::M_POLL;
				end
			endcase
		end
	end

	// Slave poll answers; avail stays off the bus unless polled
	always_ff @(posedge link.in_if_clock)
	begin
		if (lrst_reg || !slv)
		begin
			avail_o_reg <= 1'b0;
			avail_oe_reg <= 1'b0;
			ib_poll_reg <= 1'b0;
			ib_addr_reg <= 5'h00;
		end
		else if (ib)
		begin
			ib_poll_reg <= poll_act;
			ib_addr_reg <= link.in_phy_addr;
			avail_oe_reg <= ib_poll_reg;
			avail_o_reg <= chan_ok(space_reg, ib_addr_reg, busy_reg, cur_chan_reg);
		end
		else
		begin
			avail_oe_reg <= poll_act;
			avail_o_reg <= chan_ok(space_reg, link.in_phy_addr, busy_reg, cur_chan_reg);
		end
	end

	// Slave receive: a word moves on each rising edge with the enable sampled low once a start of cell, or an inband start of transfer, has selected the port
	always_comb
	begin
		take = 1'b0;
		beat_next = '0;
		if (slv && !lrst_reg && !link.in_xfer_enable_n)
		begin
			if (ib)
				take = ib_sel_reg && !link.in_start_xfer;
			else
				take = busy_reg || link.in_start_of_cell;
		end
		if (take)
		begin
			beat_next.word = link.in_cell_word;
			beat_next.sop = ib ? (rcnt_reg == 5'h00) : link.in_start_of_cell;
			beat_next.eop = ib ? (rcnt_reg == last_cnt)
				: (!link.in_start_of_cell && rcnt_reg == last_cnt);
			if (ib)
				beat_next.chan = (rcnt_reg == 5'h00) ? link.in_cell_word[4:0] : cur_chan_reg;
			else
				beat_next.chan = link.in_start_of_cell ? slv_chan_reg : cur_chan_reg;
		end
		else if (mpipe_reg)
		begin
			beat_next.word = link.in_cell_word;
			beat_next.chan = sel_reg;
			beat_next.sop = (rcnt_reg == 5'h00);
			beat_next.eop = (rcnt_reg == `CELL_WORDS - 5'h01);
		end
	end

	always_ff @(posedge link.in_if_clock)
	begin
		if (lrst_reg || !act)
		begin
			busy_reg <= 1'b0;
			ib_sel_reg <= 1'b0;
			rcnt_reg <= 5'h00;
			cur_chan_reg <= 5'h00;
			slv_chan_reg <= 5'h00;
		end
		else
		begin
			if (slv && !ib && link.in_xfer_enable_n)
				slv_chan_reg <= link.in_phy_addr;
			if (slv && ib && link.in_start_xfer)
			begin
				ib_sel_reg <= 1'b1;
				rcnt_reg <= 5'h00;
			end
			else if (take || mpipe_reg)
			begin
				busy_reg <= 1'b1;
				cur_chan_reg <= beat_next.chan;
				rcnt_reg <= beat_next.eop ? 5'h00 : (beat_next.sop ? 5'h01 : rcnt_reg + 5'h01);
				if (beat_next.eop)
				begin
					ib_sel_reg <= 1'b0;
					busy_reg <= !ib && slv;
				end
			end
		end
	end

	// Word hand-off: hold register plus toggle; the link rate leaves the hold stable
	always_ff @(posedge link.in_if_clock)
	begin
		if (lrst_reg)
		begin
			beat_reg <= 1'b0;
			tog_reg <= 1'b0;
			hold_reg <= '0;
		end
		else
		begin
			beat_reg <= take || mpipe_reg;
			if (take || mpipe_reg)
			begin
				hold_reg <= beat_next;
				tog_reg <= !tog_reg;
			end
		end
	end

	// Pins come straight from the state flops; a further stage would miss the poll timing
	assign link.enb_dev_o = enb_o_reg;
	assign link.addr_dev_o = addr_o_reg;
	assign link.addr_dev_oe = addr_oe_reg;
	assign link.valid_dev_o = valid_o_reg;
	assign link.valid_dev_oe = addr_oe_reg;
	assign link.avail_dev_o = avail_o_reg;
	assign link.avail_dev_oe = avail_oe_reg;

	always_ff @(posedge link.in_if_clock)
	begin
		link.enb_dev_oe <= mst && !lrst_reg;
	end

	always_ff @(posedge sys_clk_in)
	begin
		tog_meta_reg <= tog_reg;
		tog_sync_reg <= tog_meta_reg;
		if (rst_in)
		begin
			tog_prev_reg <= 1'b0;
			rx_valid_out <= 1'b0;
			rx_word_out <= `WORD_ZERO;
			rx_chan_out <= 5'h00;
			rx_sop_out <= 1'b0;
			rx_eop_out <= 1'b0;
		end
		else
		begin
			tog_prev_reg <= tog_sync_reg;
			rx_valid_out <= tog_sync_reg != tog_prev_reg;
			if (tog_sync_reg != tog_prev_reg)
			begin
				rx_word_out <= hold_reg.word;
				rx_chan_out <= hold_reg.chan;
				rx_sop_out <= hold_reg.sop;
				rx_eop_out <= hold_reg.eop;
			end
		end
	end
endmodule // cellbus_dev

// file: hw/cellbus_host.sv
// Partner end: makes the link clock, acts as bus master or as the polled sources
`timescale 1ns/1ps
`include "cellbus_regs.svh"
module cellbus_host (
	// System side
	input wire logic sys_clk_in,
	input wire logic rst_in,
	// Mode, same straps as the device
	input wire logic parallel_bus_select_in,
	input wire logic in_master_select_in,
	input wire logic in_inband_proto_select_in,
	// Cell request when the device is slave
	input wire logic tx_start_in,
	input wire logic [4:0] tx_chan_in,
	input wire logic tx_word_valid_in,
	input wire logic [15:0] tx_word_in,
	// Source availability when the device is master
	input wire logic [`N_CHAN-1:0] src_avail_in,
	// Status
	output logic tx_word_take_out,
	output logic tx_busy_out,
	output logic tx_refused_out,
	// Link
	cell_link_if.host link
);
	logic [2:0] div_reg;
	logic clk_reg, rise, fall, act, dev_mst, ib;
	logic s_enb_reg, s_valid_reg, s_avail_reg;
	logic [4:0] s_addr_reg, sel_reg, cnt_reg;
	logic [1:0] wait_reg;
	logic pend_reg, first_reg, rst_prev_reg;
	cellbus_pkg::host_state_t h_reg;

	assign rise = div_reg == `LINK_RISE_AT;
	assign fall = div_reg == `LINK_FALL_AT;
	assign act = parallel_bus_select_in;
	assign dev_mst = in_master_select_in && !in_inband_proto_select_in;
	assign ib = in_inband_proto_select_in;

	// Divider; pins are sampled just before the rise and driven at the fall
	// Restarted on the first reset edge, then kept running so the link side sees the reset
	always_ff @(posedge sys_clk_in)
	begin
		rst_prev_reg <= rst_in;
		if (!rst_in || rst_prev_reg)
		begin
			div_reg <= div_reg + 3'h1;
			clk_reg <= (div_reg >= `LINK_RISE_AT) && !fall;
		end
		else
		begin
			div_reg <= 3'h0;
			clk_reg <= 1'b0;
		end
	end
	assign link.in_if_clock = clk_reg;

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s_enb_reg <= 1'b1;
			s_valid_reg <= 1'b0;
			s_avail_reg <= 1'b0;
			s_addr_reg <= `IDLE_ADDR;
		end
		else if (rise)
		begin
			s_enb_reg <= link.in_xfer_enable_n;
			s_valid_reg <= link.in_addr_valid;
			s_avail_reg <= link.in_cell_avail;
			s_addr_reg <= link.in_phy_addr;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in || !act)
		begin
			h_reg <= cellbus_pkg::H_IDLE;
			pend_reg <= 1'b0;
			first_reg <= 1'b0;
			sel_reg <= 5'h00;
			cnt_reg <= 5'h00;
			wait_reg <= 2'h0;
			tx_take_clear();
		end
		else
		begin
			tx_word_take_out <= 1'b0;
			tx_refused_out <= 1'b0;
			if (tx_start_in)
				pend_reg <= 1'b1;
			if (fall && dev_mst)
			begin
				// Acting as the polled sources
				link.avail_host_oe <= s_valid_reg;
				link.avail_host_o <= src_avail_in[s_addr_reg];
				if (s_enb_reg)
					sel_reg <= s_addr_reg;
				else
				begin
					link.in_cell_word <= tx_word_in;
					tx_word_take_out <= 1'b1;
				end
			end
			else if (fall)
			begin
				link.avail_host_oe <= 1'b0;
				link.in_start_xfer <= 1'b0;
				link.in_start_of_cell <= 1'b0;
				link.valid_host_o <= ib;
				case (h_reg)
					cellbus_pkg::H_IDLE:
					begin
						link.enb_host_o <= 1'b1;
						if (pend_reg || tx_start_in)
						begin
							pend_reg <= 1'b0;
							sel_reg <= tx_chan_in;
							link.addr_host_o <= tx_chan_in;
							link.valid_host_o <= !ib;
							h_reg <= cellbus_pkg::H_POLL;
						end
					end
					cellbus_pkg::H_POLL:
					begin
						wait_reg <= ib ? 2'h1 : 2'h0;
						h_reg <= cellbus_pkg::H_WAIT;
					end
					cellbus_pkg::H_WAIT:
					begin
						wait_reg <= wait_reg - 2'h1;
						if (wait_reg == 2'h0)
						begin
							if (s_avail_reg)
							begin
								link.in_start_xfer <= ib;
								cnt_reg <= 5'h00;
								first_reg <= 1'b1;
								h_reg <= cellbus_pkg::H_XFER;
							end
							else
							begin
								tx_refused_out <= 1'b1;
								h_reg <= cellbus_pkg::H_IDLE;
							end
						end
					end
					cellbus_pkg::H_XFER:
					begin
						if (ib && first_reg)
						begin
							link.enb_host_o <= 1'b0;
							link.in_cell_word <= {11'h000, sel_reg};
							first_reg <= 1'b0;
							cnt_reg <= 5'h01;
						end
						else if (!tx_word_valid_in)
							link.enb_host_o <= 1'b1;
						else
						begin
							link.enb_host_o <= 1'b0;
							link.in_start_of_cell <= first_reg && !ib;
							first_reg <= 1'b0;
							link.in_cell_word <= tx_word_in;
							tx_word_take_out <= 1'b1;
							cnt_reg <= cnt_reg + 5'h01;
							if (cnt_reg == (ib ? `INBAND_WORDS : `CELL_WORDS) - 5'h01)
								h_reg <= cellbus_pkg::H_IDLE;
						end
					end
					default:
					begin
						h_reg <= cellbus_pkg::H_IDLE;
					end
				endcase
			end
		end
	end

	task automatic tx_take_clear();
		tx_word_take_out <= 1'b0;
		tx_refused_out <= 1'b0;
		link.enb_host_o <= 1'b1;
		link.addr_host_o <= `IDLE_ADDR;
		// Idle valid must be the inactive level, or an inband slave sees a poll
		link.valid_host_o <= in_inband_proto_select_in;
		link.avail_host_o <= 1'b0;
		link.avail_host_oe <= 1'b0;
		link.in_cell_word <= `WORD_ZERO;
		link.in_start_xfer <= 1'b0;
		link.in_start_of_cell <= 1'b0;
	endtask

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			link.enb_host_oe <= 1'b0;
			link.addr_host_oe <= 1'b0;
			link.valid_host_oe <= 1'b0;
			tx_busy_out <= 1'b0;
		end
		else
		begin
			link.enb_host_oe <= act && !in_master_select_in;
			link.addr_host_oe <= act && !in_master_select_in;
			link.valid_host_oe <= act && !in_master_select_in;
			tx_busy_out <= h_reg != cellbus_pkg::H_IDLE;
		end
	end
endmodule // cellbus_host

// file: verification/cell_bus_input_port_control_chk.sv
// Protocol checker on the link between the two port ends
`timescale 1ns/1ps
module cell_bus_input_port_control_chk (
	// Clock, reset and straps
	input wire logic in_if_clock,
	input wire logic rst_in,
	input wire logic parallel_bus_select_in,
	input wire logic in_master_select_in,
	input wire logic in_inband_proto_select_in,
	// Resolved link
	input wire logic in_xfer_enable_n,
	input wire logic [4:0] in_phy_addr,
	input wire logic in_addr_valid,
	input wire logic in_cell_avail,
	// Drive enables
	input wire logic enb_dev_oe,
	input wire logic avail_dev_oe,
	input wire logic avail_host_oe,
	input wire logic valid_host_oe
);
	logic [7:0] low_cnt_reg;
	wire logic mst = parallel_bus_select_in && in_master_select_in && !in_inband_proto_select_in;
	wire logic soc_slv = parallel_bus_select_in && !in_master_select_in && !in_inband_proto_select_in;
	wire logic ib_slv = parallel_bus_select_in && !in_master_select_in && in_inband_proto_select_in;
	// Length of the current enable-low run
	always_ff @(posedge in_if_clock)
	begin
		if (rst_in || in_xfer_enable_n)
			low_cnt_reg <= 8'h00;
		else if (low_cnt_reg != 8'hff)
			low_cnt_reg <= low_cnt_reg + 8'h01;
	end
	default clocking cb @(posedge in_if_clock); endclocking
	default disable iff (rst_in);
	// Mode terms in $past keep pre-reset history of another mode out
	chk_gap_idle_addr: assert property (
		mst && $past(mst) && $past(in_addr_valid) && !in_addr_valid |-> in_phy_addr == 5'h1f)
		else $error("gap cycle without idle address");
	chk_gap_no_avail: assert property (
		mst && $past(mst, 2) && $past(in_addr_valid, 2) && !$past(in_addr_valid) |-> !avail_host_oe)
		else $error("source drove avail after gap");
	chk_poll_incr: assert property (
		mst && $past(mst, 2) && in_addr_valid && $past(in_addr_valid, 2) && !$past(in_addr_valid)
		|-> in_phy_addr == $past(in_phy_addr, 2) + 5'h01)
		else $error("poll address not incremented");
	chk_master_select: assert property (
		mst && $past(mst, 3) && $fell(in_xfer_enable_n)
		|-> $past(in_phy_addr) == $past(in_phy_addr, 3) && $past(in_cell_avail, 2))
		else $error("selected source not the polled available one");
	chk_cell_len: assert property (
		mst && $past(enb_dev_oe) && $rose(in_xfer_enable_n) |-> low_cnt_reg == 8'h1b)
		else $error("master enable low run not one cell");
	chk_soc_answer: assert property (
		soc_slv && $past(soc_slv) && $past(valid_host_oe) |-> avail_dev_oe == $past(in_addr_valid))
		else $error("start-of-cell poll answer wrong");
	chk_inband_answer: assert property (
		ib_slv && $past(ib_slv, 2) && $past(valid_host_oe, 2) |-> avail_dev_oe != $past(in_addr_valid, 2))
		else $error("inband poll answer wrong");
	chk_sel_off: assert property (
		!parallel_bus_select_in && !$past(parallel_bus_select_in, 4) |-> !enb_dev_oe && !avail_dev_oe)
		else $error("deselected port drives link");
endmodule // cell_bus_input_port_control_chk

// file: verification/tb_cell_bus_input_port_control.sv
// Self-checking bench joining both ends of the input cell bus port
`timescale 1ns/1ps
module tb_cell_bus_input_port_control;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic sel = 1'b1;
	logic msel = 1'b0;
	logic isel = 1'b0;
	logic [31:0] space = 32'hffffffff;
	logic [31:0] src = 32'h00000000;
	logic start = 1'b0;
	logic [4:0] tchan = 5'h00;
	logic tvalid = 1'b0;
	logic [15:0] tword = 16'h0000;
	logic [15:0] rword;
	logic [4:0] rchan;
	logic rsop, reop, rvalid, take, busy, refused;
	cellbus_pkg::beat_t exp_q[$];
	int mismatches = 0;
	int n_tests = 0;
	int cyc = 0;
	int takes = 0;
	int refusals = 0;
	int k;
	logic [4:0] ch;
	cell_link_if link();
	cellbus_dev cellbus_dev_inst (.sys_clk_in(clk), .rst_in(rst), .parallel_bus_select_in(sel),
		.in_master_select_in(msel), .in_inband_proto_select_in(isel), .chan_space_in(space),
		.rx_word_out(rword), .rx_chan_out(rchan), .rx_sop_out(rsop), .rx_eop_out(reop),
		.rx_valid_out(rvalid), .link(link));
	cellbus_host cellbus_host_inst (.sys_clk_in(clk), .rst_in(rst), .parallel_bus_select_in(sel),
		.in_master_select_in(msel), .in_inband_proto_select_in(isel), .tx_start_in(start),
		.tx_chan_in(tchan), .tx_word_valid_in(tvalid), .tx_word_in(tword), .src_avail_in(src),
		.tx_word_take_out(take), .tx_busy_out(busy), .tx_refused_out(refused), .link(link));
	cell_bus_input_port_control_chk cell_bus_input_port_control_chk_inst (.in_if_clock(link.in_if_clock),
		.rst_in(rst), .parallel_bus_select_in(sel), .in_master_select_in(msel),
		.in_inband_proto_select_in(isel), .in_xfer_enable_n(link.in_xfer_enable_n),
		.in_phy_addr(link.in_phy_addr), .in_addr_valid(link.in_addr_valid),
		.in_cell_avail(link.in_cell_avail), .enb_dev_oe(link.enb_dev_oe), .avail_dev_oe(link.avail_dev_oe),
		.avail_host_oe(link.avail_host_oe), .valid_host_oe(link.valid_host_oe));
	always #2.5 clk = ~clk;
	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic check_beat(input cellbus_pkg::beat_t got);
		n_tests++;
		if (exp_q.size() == 0 || got !== exp_q[0])
		begin
			mismatches++;
			$display("BAD t=%0t word %h chan %h ends %b%b", $time, got.word, got.chan, got.sop, got.eop);
		end
		if (exp_q.size() != 0)
			void'(exp_q.pop_front());
	endtask
	always @(posedge clk)
	begin
		takes += (take === 1'b1);
		refusals += (refused === 1'b1);
		if (rvalid === 1'b1)
			check_beat({rsop, reop, rchan, rword});
		cyc++;
		if (cyc == 30000)
		begin
			mismatches++;
			$display("BAD t=%0t run did not finish", $time);
			conclude();
		end
	end
	// Straps are synced on the link clock, so modes change only under reset
	task automatic do_reset(input logic m, input logic ib, input logic s);
		@(posedge clk);
		#1 rst = 1'b1;
		msel = m;
		isel = ib;
		sel = s;
		repeat (48) @(posedge clk);
		#1 rst = 1'b0;
		check_val(32'(link.avail_dev_oe), 32'h0, "avail drive");
		check_val(32'(link.in_xfer_enable_n), 32'h1, "enable");
		repeat (40) @(posedge clk);
		#1;
	endtask
	// Word held until the edge at which take is seen high
	task automatic send_cell(input logic [4:0] c, input int n, input logic ib, input logic st, input logic pause);
		logic [15:0] w [28];
		int i;
		int g;
		for (i = 0; i < 28; i++)
			w[i] = 16'($urandom);
		if (ib)
			w[0] = {11'h000, c};
		i = 0;
		// Partner makes the channel prepend itself, without a take pulse
		if (ib && n != 0)
		begin
			exp_q.push_back({1'b1, 1'b0, c, w[0]});
			i = 1;
		end
		tchan = c;
		tword = w[i];
		tvalid = 1'b1;
		start = st;
		for (g = 0; g < 4000 && i < n; g++)
		begin
			@(posedge clk);
			if (take === 1'b1)
			begin
				exp_q.push_back({i == 0, i == n - 1, c, w[i]});
				i++;
			end
			#1 start = 1'b0;
			tword = w[i < n ? i : 0];
			if (i == 1)
				src = 32'h00000000;
			if (pause)
				tvalid = ($urandom_range(0, 3) != 0);
		end
		if (n == 0)
			@(posedge clk) #1 start = 1'b0;
		tvalid = 1'b0;
		check_val(32'(i), 32'(n), "words taken");
	endtask
	task automatic drain();
		for (int g = 0; g < 600 && exp_q.size() != 0; g++)
			@(posedge clk);
		#1 check_val(32'(exp_q.size()), 32'h0, "words lost");
	endtask
	initial
	begin
		void'($urandom(32'hf83c));
		do_reset(1'b0, 1'b0, 1'b1);
		ch = 5'($urandom_range(0, 30));
		for (k = 0; k < 2; k++)
			send_cell(ch + 5'(k), 27, 1'b0, 1'b1, 1'b1);
		drain();
		do_reset(1'b0, 1'b1, 1'b1);
		for (k = 0; k < 2; k++)
			send_cell(5'($urandom), 28, 1'b1, 1'b1, 1'b1);
		drain();
		ch = 5'($urandom);
		space[ch] = 1'b0;
		// Space word must cross into the link domain before the poll
		repeat (40) @(posedge clk);
		#1 send_cell(ch, 0, 1'b1, 1'b1, 1'b0);
		repeat (300) @(posedge clk);
		check_val(32'(refusals != 0), 32'h1, "refusal");
		space = 32'hffffffff;
		do_reset(1'b1, 1'b0, 1'b1);
		for (k = 0; k < 2; k++)
		begin
			ch = 5'($urandom);
			src[ch] = 1'b1;
			send_cell(ch, 27, 1'b0, 1'b0, 1'b0);
		end
		drain();
		do_reset(1'b0, 1'b0, 1'b0);
		k = takes;
		send_cell(5'h03, 0, 1'b0, 1'b1, 1'b0);
		repeat (300) @(posedge clk);
		check_val(32'(takes - k), 32'h0, "takes");
		check_val(32'(link.enb_dev_oe | link.avail_dev_oe), 32'h0, "drive");
		conclude();
	end
endmodule // tb_cell_bus_input_port_control
